// ==== rtl/cskip_unit.sv ====
// Purpose: execution unit for compare-skip, decimal adjust and decrement
// Assumes: Wishbone classic slave, 25 MHz clock, one instruction at a time
// Notes:   data memory is a local array reached through the bus window
//
// Operation
// - Compare-skip-greater skips when memory byte exceeds working reg, flags kept.
// - Compare-skip-less skips when memory byte is below working reg, unsigned.
// - A met compare discards the fetched word and runs an idle instruction.
// - Compare takes one cycle, two when skipping, three past a two-word target.
// - Bank bit 0 uses the access bank, bank bit 1 uses the bank select register.
// - Decimal adjust adds 6 to the low nibble if above 9 or digit carry set.
// - Decimal adjust adds 6 to the high nibble if above 9 or carry set.
// - Decimal adjust may set carry regardless of its old value.
// - Decimal adjust is the single-cycle word 0007 with no operands.
// - Decrement-file subtracts one and writes the selected destination.
// - Decrement-file updates carry, digit carry, negative, overflow, zero.
// - Decrement-file is encoded 0000 01, destination, bank bit, address.
`timescale 1ns/1ps
`default_nettype none
`include "cskip_defines.svh"

module cskip_unit
#(
  parameter int MEM_DEPTH = 4096
)
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             busy_o,
  output logic             skip_o
);
  import cskip_pkg::*;

  // ****************************************
  // Timing
  // ****************************************
  // One instruction cycle spans four clock phases
  localparam int CYC_CLKS = `INSTR_T_NS / `CLK_NS;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    phase_state_t st;
    logic [1:0]   phase;
    logic [1:0]   icyc;
    logic         skip;
    logic         two_word;
    logic [7:0]   work;
    logic [3:0]   bank;
    logic [4:0]   status;
    logic [15:0]  instr;
    logic [11:0]  maddr;
    logic [7:0]   operand;
    logic [7:0]   result;
    logic [31:0]  rdat;
    logic         ack;
    logic         busy;
  } state_t;

  state_t     s_r;
  state_t     s_nxt;
  decoded_t   dec;
  logic [7:0] mem [MEM_DEPTH];
  logic       mem_we;
  logic [11:0] mem_wa;
  logic [7:0] mem_wd;
  logic [11:0] eff_addr;
  logic       bus_req;
  logic [7:0] dec_res;
  logic [8:0] lo_sum;
  logic [8:0] hi_sum;

  instr_decode u_decode
  (
    .instr_i (s_r.instr),
    .dec_o   (dec)
  );

  // ****************************************
  // Operand address
  // ****************************************
  // Access bank: low half in bank 0, high half in the top bank
  always_comb
  begin
    if (!dec.bank_sel)
    begin
      if (dec.file_addr < `ACCESS_SPLIT)
        eff_addr = {4'h0, dec.file_addr};
      else
        eff_addr = {4'hf, dec.file_addr};
    end
    else
    begin
      eff_addr = {s_r.bank, dec.file_addr};
    end
  end

  // The held cycle after ack is not taken as a second request
  assign bus_req = cyc_i && stb_i && !s_r.ack;

  // ****************************************
  // Next state
  // ****************************************
  // Bus access and execution share one process so all state stays coherent
  always_comb
  begin
    s_nxt   = s_r;
    mem_we  = 1'b0;
    mem_wa  = s_r.maddr;
    mem_wd  = 8'h00;
    dec_res = s_r.operand - 8'h01;
    lo_sum  = 9'h000;
    hi_sum  = 9'h000;
    s_nxt.ack = 1'b0;
    // Wishbone slave: one wait state, ack for one cycle
    if (bus_req)
    begin
      s_nxt.ack  = 1'b1;
      s_nxt.rdat = 32'h0000_0000;
      case (adr_i)
        `REG_CTRL:
        begin
          s_nxt.rdat = {29'h0, s_r.two_word, s_r.skip, s_r.busy};
          if (we_i && sel_i[0] && !s_r.busy && dat_i[0])
          begin
            s_nxt.busy     = 1'b1;
            s_nxt.two_word = dat_i[1];
            s_nxt.skip     = 1'b0;
            s_nxt.st       = ST_EXEC;
            s_nxt.phase    = 2'd0;
            s_nxt.icyc     = 2'd0;
          end
        end
        `REG_WORKING:
        begin
          s_nxt.rdat = {24'h0, s_r.work};
          if (we_i && sel_i[0] && !s_r.busy)
            s_nxt.work = dat_i[7:0];
        end
        `REG_BANKSEL:
        begin
          s_nxt.rdat = {28'h0, s_r.bank};
          if (we_i && sel_i[0] && !s_r.busy)
            s_nxt.bank = dat_i[3:0];
        end
        `REG_STATUS:
        begin
          s_nxt.rdat = {27'h0, s_r.status};
          if (we_i && sel_i[0] && !s_r.busy)
            s_nxt.status = dat_i[4:0];
        end
        `REG_INSTR:
        begin
          s_nxt.rdat = {16'h0, s_r.instr};
          if (we_i && !s_r.busy)
          begin
            if (sel_i[0])
              s_nxt.instr[7:0] = dat_i[7:0];
            if (sel_i[1])
              s_nxt.instr[15:8] = dat_i[15:8];
          end
        end
        `REG_MEM_ADDR:
        begin
          s_nxt.rdat = {20'h0, s_r.maddr};
          if (we_i && sel_i[0])
            s_nxt.maddr[7:0] = dat_i[7:0];
          if (we_i && sel_i[1])
            s_nxt.maddr[11:8] = dat_i[11:8];
        end
        `REG_MEM_DATA:
        begin
          s_nxt.rdat = {24'h0, mem[s_r.maddr]};
          if (we_i && sel_i[0] && !s_r.busy)
          begin
            mem_we = 1'b1;
            mem_wd = dat_i[7:0];
          end
        end
        `REG_RESULT:
        begin
          s_nxt.rdat = {24'h0, s_r.result};
        end
        default:
        begin
          s_nxt.rdat = 32'h0000_0000;   // Unmapped reads zero, writes dropped
        end
      endcase
    end

    // Execution, four phases per instruction cycle
    case (s_r.st)
      ST_IDLE:
      begin
        s_nxt.phase = 2'd0;
      end
      ST_EXEC:
      begin
        s_nxt.phase = s_r.phase + 2'd1;
        case (s_r.phase)
          2'd1:
          begin
            s_nxt.operand = mem[eff_addr];
          end
          2'd2:
          begin
            if (dec.kind == OPK_CMP)
            begin
              // Flags untouched by compares
              if (dec.is_gt)
                s_nxt.skip = s_r.operand > s_r.work;
              else
                s_nxt.skip = s_r.operand < s_r.work;
            end
            else if (dec.kind == OPK_DAW)
            begin
              lo_sum = {1'b0, s_r.work};
              if (s_r.work[3:0] > `BCD_LIMIT || s_r.status[`ST_DC])
                lo_sum = lo_sum + {5'h00, `BCD_ADJ};
              hi_sum = lo_sum;
              if (lo_sum[7:4] > `BCD_LIMIT || s_r.status[`ST_C])
                hi_sum = lo_sum + {1'b0, `BCD_ADJ, 4'h0};
              s_nxt.result = hi_sum[7:0];
              // Carry only ever set here, never cleared
              s_nxt.status[`ST_C] = s_r.status[`ST_C] | hi_sum[8] | lo_sum[8];
            end
            else if (dec.kind == OPK_DEC)
            begin
              s_nxt.result = dec_res;
              // Borrow-style carry: set when no borrow
              s_nxt.status[`ST_C]  = s_r.operand != 8'h00;
              s_nxt.status[`ST_DC] = s_r.operand[3:0] != 4'h0;
              s_nxt.status[`ST_N]  = dec_res[7];
              s_nxt.status[`ST_Z]  = dec_res == 8'h00;
              s_nxt.status[`ST_OV] = s_r.operand == 8'h80;
            end
          end
          2'd3:
          begin
            // Compares have no write-back
            if (dec.kind == OPK_DAW)
              s_nxt.work = s_r.result;
            // Decrement destination is picked after this case
            if (dec.kind == OPK_CMP && s_r.skip)
              s_nxt.st = ST_SKIP1;
            else
              s_nxt.st = ST_DONE;
          end
          default:
          begin
            s_nxt.phase = s_r.phase + 2'd1;
          end
        endcase
      end
      ST_SKIP1:
      begin
        // Discarded fetch runs as an idle instruction
        s_nxt.phase = s_r.phase + 2'd1;
        if (s_r.phase == `PHASES)
          s_nxt.st = s_r.two_word ? ST_SKIP2 : ST_DONE;
      end
      ST_SKIP2:
      begin
        s_nxt.phase = s_r.phase + 2'd1;
        if (s_r.phase == `PHASES)
          s_nxt.st = ST_DONE;
      end
      ST_DONE:
      begin
        // Extra clock so result and status settle before busy falls
        s_nxt.busy = 1'b0;
        s_nxt.st   = ST_IDLE;
      end
      default:
      begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    // Decrement write-back to memory or working register
    if (s_r.st == ST_EXEC && s_r.phase == 2'd3 && dec.kind == OPK_DEC)
    begin
      if (dec.dest_file)
      begin
        mem_we = 1'b1;
        mem_wa = eff_addr;
        mem_wd = s_r.result;
      end
      else
      begin
        s_nxt.work = s_r.result;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Clock enable freezes everything including the bus answer
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_r        <= '0;
      s_r.st     <= ST_IDLE;
      s_r.work   <= `RST_WORKING;
      s_r.bank   <= `RST_BANKSEL;
      s_r.status <= `RST_STATUS;
    end
    else if (ce_i)
    begin
      s_r <= s_nxt;
    end
  end

  // Memory array, no reset so it maps onto block RAM
  always_ff @(posedge clk_i)
  begin
    if (ce_i && mem_we && !reset_i)
      mem[mem_wa] <= mem_wd;
  end

  assign dat_o  = s_r.rdat;
  assign ack_o  = s_r.ack;
  assign busy_o = s_r.busy;
  assign skip_o = s_r.skip;

endmodule
`default_nettype wire

// ==== include/cskip_defines.svh ====
// Purpose: constants for the compare/skip, decimal adjust and decrement unit
// Assumes: included by bare name
// Notes:   offsets, field positions, resets and timing counts
`ifndef CSKIP_DEFINES_SVH
`define CSKIP_DEFINES_SVH

// ****************************************
// Wishbone register offsets (byte address)
// ****************************************
`define REG_CTRL        8'h00
`define REG_WORKING     8'h04
`define REG_BANKSEL     8'h08
`define REG_STATUS      8'h0c
`define REG_INSTR       8'h10
`define REG_MEM_ADDR    8'h14
`define REG_MEM_DATA    8'h18
`define REG_RESULT      8'h1c

// ****************************************
// Status bit positions
// ****************************************
`define ST_C            0
`define ST_DC           1
`define ST_Z            2
`define ST_OV           3
`define ST_N            4

// ****************************************
// Opcode patterns and decimal adjust constants
// ****************************************
`define OP_GT_HI        7'h32
`define OP_LT_HI        7'h30
`define OP_DEC_HI       6'h01
`define OP_DAW          16'h0007
`define BCD_LIMIT       4'h9
`define BCD_ADJ         4'h6

// ****************************************
// Reset values, access bank split and timing
// ****************************************
`define RST_WORKING     8'h00
`define RST_BANKSEL     4'h0
`define RST_STATUS      5'h00
`define ACCESS_SPLIT    8'h80
`define PHASES          2'd3
`define INSTR_T_NS      160
`define CLK_NS          40

`endif

// ==== include/cskip_pkg.sv ====
// Purpose: types for the compare/skip, decimal adjust and decrement unit
// Assumes: nothing
// Notes:   state and carriers only; numbers live in the defines header
package cskip_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EXEC,
    ST_SKIP1,
    ST_SKIP2,
    ST_DONE
  } phase_state_t;

  typedef enum logic [1:0] {
    OPK_NONE,
    OPK_CMP,
    OPK_DAW,
    OPK_DEC
  } op_kind_t;

  typedef struct packed {
    logic [31:0] dat;
    logic        ack;
  } wb_resp_t;

  typedef struct packed {
    op_kind_t  kind;
    logic      is_gt;
    logic      dest_file;
    logic      bank_sel;
    logic [7:0] file_addr;
  } decoded_t;

endpackage

// ==== rtl/instr_decode.sv ====
// Purpose: combinational opcode decode for the unit
// Assumes: 16-bit instruction word
// Notes:   unknown words decode to no operation
`timescale 1ns/1ps
`default_nettype none
`include "cskip_defines.svh"

module instr_decode
(
  input  wire logic [15:0]        instr_i,
  output var cskip_pkg::decoded_t dec_o
);
  import cskip_pkg::*;

  // ****************************************
  // Decode
  // ****************************************
  // Field split common to all file-operand forms
  always_comb
  begin
    dec_o           = '0;
    dec_o.kind      = OPK_NONE;
    dec_o.file_addr = instr_i[7:0];
    dec_o.bank_sel  = instr_i[8];
    dec_o.dest_file = instr_i[9];
    if (instr_i[15:9] == `OP_GT_HI)
    begin
      dec_o.kind  = OPK_CMP;
      dec_o.is_gt = 1'b1;
    end
    else if (instr_i[15:9] == `OP_LT_HI)
    begin
      dec_o.kind  = OPK_CMP;
    end
    else if (instr_i == `OP_DAW)
    begin
      dec_o.kind  = OPK_DAW;
    end
    else if (instr_i[15:10] == `OP_DEC_HI)
    begin
      dec_o.kind  = OPK_DEC;
    end
  end

endmodule
`default_nettype wire

// ==== sim/cskip_unit_asserts.sv ====
// Purpose: port-level checks for the compare/skip execution unit
// Assumes: bound to cskip_unit, single clock domain
// Notes:   bus answer timing and busy/skip behaviour only
`timescale 1ns/1ps
`default_nettype none
`include "cskip_defines.svh"

module cskip_unit_asserts
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack_o,
  input  wire logic        busy_o,
  input  wire logic        skip_o
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Bus answer comes exactly one cycle after a taken request
  AST_ACK_NEXT:
    assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE:
    assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE:
    assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  // Read data only moves with an answer, so software never sees a glitch
  AST_DAT_HOLD:
    assert property ($changed(dat_o) |-> ack_o)
    else $error("read data changed without ack");
  AST_START:
    assert property (ack_o && $past(we_i && adr_i == `REG_CTRL && sel_i[0]
      && dat_i[0] && !busy_o) |-> busy_o)
    else $error("start did not raise busy");
  AST_BUSY_ACK:
    assert property ($rose(busy_o) |-> ack_o)
    else $error("busy rose away from start ack");
  AST_BUSY_MIN:
    assert property ($rose(busy_o) |=> busy_o [*3])
    else $error("execution shorter than four phases");
  AST_BUSY_MAX:
    assert property ($rose(busy_o) |-> ##[1:16] !busy_o)
    else $error("execution too long");
  AST_SKIP_SRC:
    assert property ($changed(skip_o) |-> busy_o || $past(busy_o))
    else $error("skip changed outside an operation");
  // Clock enable low holds every registered output for that edge
  AST_CE_FREEZE:
    assert property (!ce_i |=> $stable(busy_o) && $stable(skip_o)
      && $stable(ack_o) && $stable(dat_o))
    else $error("outputs moved while clock enable low");
endmodule
`default_nettype wire

// ==== sim/compare_skip_bcd_decrement_ops_tb_top.sv ====
// Purpose: self-checking bench for the compare/skip execution unit
// Assumes: classic Wishbone register map, 25 MHz clock
// Notes:   cycle counts are compared relative to a one-cycle instruction
`timescale 1ns/1ps
`default_nettype none
`include "cskip_defines.svh"

module compare_skip_bcd_decrement_ops_tb_top;
  typedef struct packed {
    logic [15:0] ins;
    logic [7:0]  w;
    logic [7:0]  m;
    logic [3:0]  b;
    logic [4:0]  st;
    logic [4:0]  mk;
    logic [7:0]  ew;
    logic [7:0]  em;
    logic        sk;
    logic [4:0]  est;
  } row_t;
  logic        clk_i = 1'h0;
  logic        reset_i = 1'h1;
  logic        ce_i = 1'h1;
  logic        cyc_i = 1'h0;
  logic        stb_i = 1'h0;
  logic        we_i = 1'h0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        busy_o;
  logic        skip_o;
  logic [31:0] rdat;
  logic [11:0] ea;
  row_t        r;
  int          err_count = 0;
  int          comparisons = 0;
  int          cyc_n;
  int          base;
  // Rows: compares first (non-skip first sets the base), then adjust, decrement
  row_t rows [13] = '{
    '{16'h6410,8'h80,8'h80,4'h0,5'h15,5'h1f,8'h80,8'h80,1'h0,5'h15},
    '{16'h6410,8'h80,8'h81,4'h0,5'h15,5'h1f,8'h80,8'h81,1'h1,5'h15},
    '{16'h6010,8'h80,8'h7f,4'h0,5'h0a,5'h1f,8'h80,8'h7f,1'h1,5'h0a},
    '{16'h6010,8'h80,8'h80,4'h0,5'h0a,5'h1f,8'h80,8'h80,1'h0,5'h0a},
    '{16'h6520,8'h04,8'h05,4'h3,5'h00,5'h1f,8'h04,8'h05,1'h1,5'h00},
    '{16'h6090,8'h10,8'h20,4'h0,5'h00,5'h1f,8'h10,8'h20,1'h0,5'h00},
    '{16'h0007,8'ha5,8'h00,4'h0,5'h00,5'h01,8'h05,8'h00,1'h0,5'h01},
    '{16'h0007,8'hce,8'h00,4'h0,5'h00,5'h01,8'h34,8'h00,1'h0,5'h01},
    '{16'h0007,8'h12,8'h00,4'h0,5'h02,5'h01,8'h18,8'h00,1'h0,5'h00},
    '{16'h0007,8'h45,8'h00,4'h0,5'h01,5'h01,8'ha5,8'h00,1'h0,5'h01},
    '{16'h0405,8'h33,8'h01,4'h0,5'h00,5'h1f,8'h00,8'h01,1'h0,5'h07},
    '{16'h0733,8'h33,8'h80,4'h2,5'h00,5'h1f,8'h33,8'h7f,1'h0,5'h09},
    '{16'h06a0,8'h44,8'h00,4'h0,5'h10,5'h1f,8'h44,8'hff,1'h0,5'h10}};

  cskip_unit u_dut
  (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .cyc_i   (cyc_i),
    .stb_i   (stb_i),
    .we_i    (we_i),
    .adr_i   (adr_i),
    .sel_i   (sel_i),
    .dat_i   (dat_i),
    .dat_o   (dat_o),
    .ack_o   (ack_o),
    .busy_o  (busy_o),
    .skip_o  (skip_o)
  );

  // ****************************************
  // Clock, helpers
  // ****************************************
  always #20 clk_i = ~clk_i;

  // Bank bit picks the bank register, else the split access bank
  function automatic logic [11:0] eff(input logic [15:0] ins,
                                     input logic [3:0] b);
    if (ins[8])
      return {b, ins[7:0]};
    return {{4{ins[7]}}, ins[7:0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One classic cycle; held until ack is sampled, released after it
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    // Only the watchdog ends a wait for the answer
    do
    begin
      @(posedge clk_i);
    end while (ack_o !== 1'h1);
    rdat = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    we_i  <= 1'h0;
  endtask

  task automatic mem(input logic [11:0] a, input logic [7:0] d);
    wb(1'h1, `REG_MEM_ADDR, {20'h0, a});
    wb(1'h1, `REG_MEM_DATA, {24'h0, d});
  endtask

  // Start one instruction and count the cycles busy stays high
  task automatic run(input logic [15:0] ins, input logic tw);
    wb(1'h1, `REG_INSTR, {16'h0, ins});
    wb(1'h1, `REG_CTRL, {30'h0, tw, 1'h1});
    cyc_n = 1;
    while (busy_o === 1'h1 && cyc_n < 40)
    begin
      @(posedge clk_i);
      cyc_n++;
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'h0;
    chk("busy", {31'h0, busy_o}, 32'h0);
    wb(1'h0, `REG_STATUS, 32'h0);
    chk("status rst", rdat, 32'h0);
    wb(1'h0, 8'h20, 32'h0);
    chk("unmapped", rdat, 32'h0);
    foreach (rows[i])
    begin
      r = rows[i];
      ea = eff(r.ins, r.b);
      wb(1'h1, `REG_BANKSEL, {28'h0, r.b});
      wb(1'h1, `REG_WORKING, {24'h0, r.w});
      wb(1'h1, `REG_STATUS, {27'h0, r.st});
      mem(ea, r.m);
      run(r.ins, 1'h0);
      if (r.ins[15:12] != 4'h6)
        chk("cycles", cyc_n, base);
      else if (!r.sk)
      begin
        base = cyc_n;
        // Four phases, the done clock and the closing sample
        chk("base", cyc_n, `INSTR_T_NS / `CLK_NS + 2);
      end
      else
        chk("skip cycles", cyc_n, base + 4);
      wb(1'h0, `REG_WORKING, 32'h0);
      chk("working", rdat & 32'hff, {24'h0, r.ew});
      wb(1'h0, `REG_MEM_DATA, 32'h0);
      chk("memory", rdat & 32'hff, {24'h0, r.em});
      wb(1'h0, `REG_STATUS, 32'h0);
      chk("status", rdat & r.mk, {27'h0, r.est & r.mk});
      if (r.ins[15:12] == 4'h6)
        chk("skip", {31'h0, skip_o}, {31'h0, r.sk});
    end
    // Skip over a two-word instruction costs two discarded words
    wb(1'h1, `REG_WORKING, 32'h0);
    mem(12'h010, 8'h01);
    run(16'h6410, 1'h1);
    chk("two word", cyc_n, base + 8);
    wb(1'h0, `REG_CTRL, 32'h0);
    chk("ctrl", rdat, 32'h6);
    // Working register write while busy must be ignored; the decrement
    // goes to memory so only the refused write could move W
    wb(1'h1, `REG_INSTR, 32'h0610);
    wb(1'h1, `REG_CTRL, 32'h1);
    wb(1'h1, `REG_WORKING, 32'h55);
    while (busy_o === 1'h1 && cyc_n < 80)
    begin
      @(posedge clk_i);
      cyc_n++;
    end
    wb(1'h0, `REG_WORKING, 32'h0);
    chk("busy write", rdat & 32'hff, 32'h0);
    wb(1'h0, `REG_MEM_DATA, 32'h0);
    chk("dec to file", rdat & 32'hff, 32'h0);
    wb(1'h0, `REG_RESULT, 32'h0);
    chk("result", rdat & 32'hff, 32'h0);
    // Clock enable low freezes execution; busy lasts longer by that much
    wb(1'h1, `REG_INSTR, 32'h0007);
    wb(1'h1, `REG_CTRL, 32'h1);
    ce_i <= 1'h0;
    cyc_n = 1;
    repeat (6)
    begin
      @(posedge clk_i);
      cyc_n++;
    end
    ce_i <= 1'h1;
    while (busy_o === 1'h1 && cyc_n < 80)
    begin
      @(posedge clk_i);
      cyc_n++;
    end
    chk("ce freeze", cyc_n, base + 6);
    // Flags left by the decrement: carry and digit carry both set
    wb(1'h0, `REG_WORKING, 32'h0);
    chk("ce adjust", rdat & 32'hff, 32'h66);
    final_report();
  end

  // Whole run is a few hundred cycles; 20000 means a hang
  initial
  begin
    #800000;
    err_count++;
    final_report();
  end
endmodule

bind cskip_unit cskip_unit_asserts u_chk
(
  .clk_i   (clk_i),
  .reset_i (reset_i),
  .ce_i    (ce_i),
  .cyc_i   (cyc_i),
  .stb_i   (stb_i),
  .we_i    (we_i),
  .adr_i   (adr_i),
  .sel_i   (sel_i),
  .dat_i   (dat_i),
  .dat_o   (dat_o),
  .ack_o   (ack_o),
  .busy_o  (busy_o),
  .skip_o  (skip_o)
);
`default_nettype wire
